/* File: hdl/fcs_supervisor.sv */
// Fault counter, SAFE and LATCH state supervisor of the power supply.
`timescale 1ns/1ps
`include "fcs_defs.svh"

// What this block does
// - Supply undervoltage first: SAFE, count kept, no timer.
// - First over-temperature: SAFE, count plus one, 30 s.
// - First pump undervoltage: SAFE, count plus one, 100 ms.
// - Repeat counted fault: count up, LATCH at four.
// - Over-temperature history forces 30 s window on faults from ACTIVE.
// - Repeat fault restarts refresh timer from zero.
// - Supply undervoltage after fault keeps count, window.
// - Over-temperature in supply SAFE counts, 30 s.
// - Pump fault in supply SAFE counts, 100 ms.
// - Other counted fault in SAFE: 30 s, no count.
// - Supply undervoltage in counted SAFE changes nothing.
// - Standby request enters and leaves low power.
// - Wake low always means OFF.
// - Quiet refresh window clears the fault count.
// - SAFE returns to ACTIVE only when faults disappear.
// - LATCH holds until OFF, outputs disabled.
// - OFF to ACTIVE on good supply and wake.
module fcs_supervisor
	import fcs_pkg::*;
#(
	parameter int unsigned SHORT_CYCLES = `FCS_WIN_SHORT_CYC,
	parameter int unsigned LONG_CYCLES = `FCS_WIN_LONG_CYC
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rstn_i,
	// Analog monitor levels.
	input wire fcs_faults_s faults_i,
	input wire logic battery_supply_ok_i,
	// External pins.
	input wire logic wake_i,
	input wire logic low_power_request_i,
	// Control of the regulators and monitors.
	output logic regulators_en_o,
	output logic bypass_mode_o,
	output logic monitor_en_o,
	output logic powerup_start_o,
	output logic watchdog_fault_out_o,
	// Status.
	output fcs_status_s status_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	// Registered fault levels and their previous values.
	fcs_faults_s faults_q;
	fcs_faults_s faults_prev_q;
	// State, its next value and the SAFE cause.
	fcs_state_e state_q;
	fcs_state_e state_d;
	fcs_cause_e cause_q;
	fcs_cause_e cause_d;
	// Persistent fault count.
	logic [`FCS_COUNT_W-1:0] persistent_fault_count_q;
	logic [`FCS_COUNT_W-1:0] persistent_fault_count_d;
	// Counted faults seen since the count was last cleared.
	logic seen_ot_q;
	logic seen_ot_d;
	logic seen_cp_q;
	logic seen_cp_d;
	// Selected refresh window, high for the long one.
	logic window_long_q;
	logic window_long_d;
	// Timer armed to start on return to ACTIVE.
	logic arm_q;
	logic arm_d;
	// Count hit the limit while ACTIVE; LATCH follows one cycle later.
	logic latch_pend_q;
	logic latch_pend_d;
	// Decoded fault conditions.
	// Supply faults count in any_fault, so SAFE is held until they clear as well.
	logic any_fault;
	logic ot_rise;
	logic cp_rise;
	// Refresh timer handshake.
	logic timer_restart;
	logic timer_expired;
	logic timer_running;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Adds one to the fault count without passing the limit.
	// Saturation keeps the count from wrapping back to a harmless value.
	function automatic logic [`FCS_COUNT_W-1:0] sat_inc(input logic [`FCS_COUNT_W-1:0] cnt);
		if (cnt >= `FCS_COUNT_LIMIT) begin
			return `FCS_COUNT_LIMIT;
		end
		return cnt + `FCS_COUNT_W'(1);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Input sampling

	// Fault monitor levels are flopped so one snapshot drives every fault decision; supply, wake and standby are used unflopped.
	// The previous copy resets low, the idle level of every monitor, so that
	// releasing reset never looks like a fresh fault edge.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			faults_q <= '0;
			faults_prev_q <= '0;
		end else begin
			faults_q <= faults_i;
			faults_prev_q <= faults_q;
		end
	end

	// Any failure that keeps the device in SAFE.
	assign any_fault = |faults_q;
	// New counted faults while already in SAFE are edges, not levels.
	assign ot_rise = faults_q.overtemp_shutdown && !faults_prev_q.overtemp_shutdown;
	assign cp_rise = faults_q.pump_undervoltage && !faults_prev_q.pump_undervoltage;

	////////////////////////////////////////////////////////////////////////////////
	// Next state and fault bookkeeping

	// One process decides the state and the counter together, since each
	// transition defines both; splitting them would duplicate the decode.
	always_comb begin
		state_d = state_q;
		cause_d = cause_q;
		persistent_fault_count_d = persistent_fault_count_q;
		seen_ot_d = seen_ot_q;
		seen_cp_d = seen_cp_q;
		window_long_d = window_long_q;
		arm_d = arm_q;
		latch_pend_d = 1'b0;
		timer_restart = 1'b0;
		if (!wake_i) begin
			// Wake low overrides everything, including LATCH.
			state_d = FCS_OFF;
			cause_d = FCS_CAUSE_NONE;
			persistent_fault_count_d = `FCS_COUNT_RESET;
			seen_ot_d = 1'b0;
			seen_cp_d = 1'b0;
			window_long_d = 1'b1;
			arm_d = 1'b0;
		end else begin
			unique case (state_q)
				FCS_OFF: begin
					// Faults are not acted on until the supply is good and wake is high.
					if (battery_supply_ok_i) begin
						state_d = FCS_ACTIVE;
					end
				end
				FCS_ACTIVE: begin
					if (faults_q.overtemp_shutdown || faults_q.pump_undervoltage) begin
						// Over-temperature wins when both arrive together.
						state_d = FCS_SAFE;
						persistent_fault_count_d = sat_inc(persistent_fault_count_q);
						seen_ot_d = seen_ot_q || faults_q.overtemp_shutdown;
						seen_cp_d = seen_cp_q || faults_q.pump_undervoltage;
						window_long_d = seen_ot_q || faults_q.overtemp_shutdown;
						arm_d = 1'b1;
						cause_d = faults_q.overtemp_shutdown ? FCS_CAUSE_OVERTEMP : FCS_CAUSE_PUMP;
						latch_pend_d = sat_inc(persistent_fault_count_q) == `FCS_COUNT_LIMIT;
					end else if (faults_q.supply_undervoltage || faults_q.supply_overvoltage) begin
						// Count and window stay; timer only if a counted fault is pending.
						state_d = FCS_SAFE;
						cause_d = FCS_CAUSE_SUPPLY;
						arm_d = seen_ot_q || seen_cp_q;
					end else if (low_power_request_i) begin
						state_d = FCS_LOW_POWER;
					end
				end
				FCS_LOW_POWER: begin
					// Monitoring is off here, so faults are not acted on.
					if (!low_power_request_i) begin
						state_d = FCS_ACTIVE;
					end
				end
				FCS_SAFE: begin
					if (latch_pend_q) begin
						state_d = FCS_LATCH;
					end else if (cause_q == FCS_CAUSE_SUPPLY && (ot_rise || cp_rise)) begin
						persistent_fault_count_d = sat_inc(persistent_fault_count_q);
						seen_ot_d = seen_ot_q || ot_rise;
						seen_cp_d = seen_cp_q || cp_rise;
						window_long_d = ot_rise;
						arm_d = 1'b1;
						cause_d = ot_rise ? FCS_CAUSE_OVERTEMP : FCS_CAUSE_PUMP;
						if (sat_inc(persistent_fault_count_q) == `FCS_COUNT_LIMIT) begin
							state_d = FCS_LATCH;
						end
					end else if ((cause_q == FCS_CAUSE_OVERTEMP && cp_rise)
						|| (cause_q == FCS_CAUSE_PUMP && ot_rise)) begin
						// Same SAFE episode, so no second increment.
						window_long_d = 1'b1;
						seen_ot_d = 1'b1;
						seen_cp_d = 1'b1;
					end else if (!any_fault) begin
						// Supply faults in a counted SAFE fall through here unchanged.
						state_d = FCS_ACTIVE;
						cause_d = FCS_CAUSE_NONE;
						timer_restart = arm_q;
						arm_d = 1'b0;
					end
				end
				FCS_LATCH: begin
					// Only wake low, handled above, leaves this state.
					state_d = FCS_LATCH;
				end
			endcase
		end
		// A quiet window in ACTIVE forgets all earlier counted faults.
		// A fault in the same cycle as expiry wins, since state_d then leaves ACTIVE.
		if (wake_i && state_q == FCS_ACTIVE && state_d == FCS_ACTIVE && timer_expired) begin
			persistent_fault_count_d = `FCS_COUNT_RESET;
			seen_ot_d = 1'b0;
			seen_cp_d = 1'b0;
			window_long_d = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State registers

	// State, cause and pending latch.
	// The pending latch flag lives for one cycle only and is rebuilt every cycle.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= FCS_OFF;
			cause_q <= FCS_CAUSE_NONE;
			latch_pend_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cause_q <= cause_d;
			latch_pend_q <= latch_pend_d;
		end
	end

	// Fault count, history and window selection.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			persistent_fault_count_q <= `FCS_COUNT_RESET;
			seen_ot_q <= 1'b0;
			seen_cp_q <= 1'b0;
			window_long_q <= 1'b1;
			arm_q <= 1'b0;
		end else begin
			persistent_fault_count_q <= persistent_fault_count_d;
			seen_ot_q <= seen_ot_d;
			seen_cp_q <= seen_cp_d;
			window_long_q <= window_long_d;
			arm_q <= arm_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Refresh timer

	// Runs only in ACTIVE; leaving ACTIVE abandons the current window.
	// The timer is restarted on an armed SAFE exit, so it never carries ticks over
	// from an earlier window.
	fcs_refresh_timer #(
		.SHORT_CYCLES(SHORT_CYCLES),
		.LONG_CYCLES(LONG_CYCLES)
	) u_timer (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.restart_i(timer_restart),
		.run_i(state_q == FCS_ACTIVE && wake_i),
		.long_i(window_long_q),
		.expired_o(timer_expired),
		.running_o(timer_running)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Outputs follow the next state so they line up with state_q.
	// Registering them adds no latency and keeps decode glitches off the pins.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			regulators_en_o <= 1'b0;
			bypass_mode_o <= 1'b0;
			monitor_en_o <= 1'b0;
			powerup_start_o <= 1'b0;
			watchdog_fault_out_o <= 1'b1;
		end else begin
			regulators_en_o <= state_d == FCS_ACTIVE || state_d == FCS_LOW_POWER;
			bypass_mode_o <= state_d == FCS_LOW_POWER;
			monitor_en_o <= state_d == FCS_ACTIVE || state_d == FCS_SAFE;
			powerup_start_o <= state_d == FCS_ACTIVE && (state_q == FCS_OFF || state_q == FCS_SAFE);
			watchdog_fault_out_o <= state_d != FCS_LATCH;
		end
	end

	// Status mirrors the registered bookkeeping.
	// The refresh flag shows the timer itself, not the armed request.
	assign status_o.state = state_q;
	assign status_o.persistent_fault_count = persistent_fault_count_q;
	assign status_o.window_long = window_long_q;
	assign status_o.refresh_running = timer_running;

endmodule

/* File: hdl/fcs_defs.svh */
// Constants for the fault counter and safe/latch supervisor.
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// Internal clock rate in hertz.
`define FCS_CLK_HZ 25000000
// Short refresh window, in milliseconds.
`define FCS_WIN_SHORT_MS 100
// Long refresh window, in seconds.
`define FCS_WIN_LONG_S 30
// Short window in clock cycles; dividing first keeps the product inside 32 bits.
`define FCS_WIN_SHORT_CYC ((`FCS_CLK_HZ / 1000) * `FCS_WIN_SHORT_MS)
// Long window in clock cycles.
`define FCS_WIN_LONG_CYC (`FCS_WIN_LONG_S * `FCS_CLK_HZ)
// Width of the refresh timer counter.
`define FCS_TIMER_W 30
// Width of the persistent fault count.
`define FCS_COUNT_W 3
// Fault count that forces the latch state.
`define FCS_COUNT_LIMIT 3'h4
// Fault count after reset or clearing.
`define FCS_COUNT_RESET 3'h0

`endif

/* File: hdl/fcs_pkg.sv */
// Types shared by the fault supervisor files.
package fcs_pkg;

	// Operating states of the supervisor.
	typedef enum logic [2:0] {
		FCS_OFF,
		FCS_ACTIVE,
		FCS_LOW_POWER,
		FCS_SAFE,
		FCS_LATCH
	} fcs_state_e;

	// Reason the supervisor sits in SAFE.
	typedef enum logic [1:0] {
		FCS_CAUSE_NONE,
		FCS_CAUSE_SUPPLY,
		FCS_CAUSE_OVERTEMP,
		FCS_CAUSE_PUMP
	} fcs_cause_e;

	// Fault levels from the analog monitors.
	typedef struct packed {
		logic overtemp_shutdown;
		logic pump_undervoltage;
		logic supply_undervoltage;
		logic supply_overvoltage;
	} fcs_faults_s;

	// Supervisor status seen by the rest of the chip.
	typedef struct packed {
		fcs_state_e state;
		logic [2:0] persistent_fault_count;
		logic window_long;
		logic refresh_running;
	} fcs_status_s;

endpackage

/* File: hdl/fcs_refresh_timer.sv */
// Refresh timer that measures the fault refresh window.
`timescale 1ns/1ps
`include "fcs_defs.svh"

module fcs_refresh_timer #(
	parameter int unsigned SHORT_CYCLES = `FCS_WIN_SHORT_CYC,
	parameter int unsigned LONG_CYCLES = `FCS_WIN_LONG_CYC
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rstn_i,
	// Control.
	input wire logic restart_i,
	input wire logic run_i,
	input wire logic long_i,
	// Result.
	output logic expired_o,
	output logic running_o
);

	// Cycles counted since the last restart.
	logic [`FCS_TIMER_W-1:0] ticks_q;
	// High while the timer is counting.
	logic run_q;
	// Last tick of the selected window.
	logic [`FCS_TIMER_W-1:0] last_tick;

	// The window can change while counting; the new length applies at once.
	assign last_tick = long_i ? `FCS_TIMER_W'(LONG_CYCLES - 1) : `FCS_TIMER_W'(SHORT_CYCLES - 1);

	// Counts clock ticks while enabled; a restart always begins from zero.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ticks_q <= '0;
			run_q <= 1'b0;
		end else if (restart_i) begin
			ticks_q <= '0;
			run_q <= 1'b1;
		end else if (!run_i || (run_q && ticks_q == last_tick)) begin
			// Stopping on expiry gives a single expiry pulse per window.
			ticks_q <= '0;
			run_q <= 1'b0;
		end else if (run_q) begin
			ticks_q <= ticks_q + `FCS_TIMER_W'(1);
		end
	end

	// Expiry is a one-cycle pulse on the last tick of the window.
	assign expired_o = run_q && run_i && !restart_i && ticks_q == last_tick;
	assign running_o = run_q;

endmodule

/* File: testbench/fcs_supervisor_props.sv */
// Port checks of the fault supervisor.
`timescale 1ns/1ps
module fcs_supervisor_props
	import fcs_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rstn_i,
	// Inputs.
	input wire fcs_faults_s faults_i,
	input wire logic battery_supply_ok_i,
	input wire logic wake_i,
	input wire logic low_power_request_i,
	// Outputs.
	input wire logic regulators_en_o,
	input wire logic bypass_mode_o,
	input wire logic monitor_en_o,
	input wire logic powerup_start_o,
	input wire logic watchdog_fault_out_o,
	input wire fcs_status_s status_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	// The registered fault level is the input one edge back, so $past stands in for it.
	property p_wake_off;
		!wake_i |=> status_o.state == FCS_OFF;
	endproperty
	a_wake_off: assert property (p_wake_off) else $error("wake low did not give off");
	property p_off_start;
		status_o.state == FCS_OFF && wake_i && battery_supply_ok_i |=> status_o.state == FCS_ACTIVE;
	endproperty
	a_off_start: assert property (p_off_start) else $error("no start from off");
	property p_fault_safe;
		status_o.state == FCS_ACTIVE && wake_i && $past(faults_i) != 4'h0 |=> status_o.state == FCS_SAFE;
	endproperty
	a_fault_safe: assert property (p_fault_safe) else $error("fault did not give safe");
	property p_safe_hold;
		status_o.state == FCS_SAFE && wake_i && $past(faults_i) != 4'h0
			|=> status_o.state inside {FCS_SAFE, FCS_LATCH};
	endproperty
	a_safe_hold: assert property (p_safe_hold) else $error("safe left while faulty");
	property p_four_latch;
		status_o.state == FCS_SAFE && status_o.persistent_fault_count == 3'h4 && wake_i
			|=> status_o.state == FCS_LATCH;
	endproperty
	a_four_latch: assert property (p_four_latch) else $error("count four did not latch");
	property p_latch_hold;
		status_o.state == FCS_LATCH && wake_i |=> status_o.state == FCS_LATCH;
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch left while awake");
	property p_latch_out;
		status_o.state == FCS_LATCH |-> !watchdog_fault_out_o && !monitor_en_o && !regulators_en_o;
	endproperty
	a_latch_out: assert property (p_latch_out) else $error("outputs live in latch");
	property p_count_cap;
		status_o.persistent_fault_count <= 3'h4;
	endproperty
	a_count_cap: assert property (p_count_cap) else $error("fault count above four");
	property p_lp_enter;
		status_o.state == FCS_ACTIVE && wake_i && low_power_request_i && $past(faults_i) == 4'h0
			|=> status_o.state == FCS_LOW_POWER && bypass_mode_o;
	endproperty
	a_lp_enter: assert property (p_lp_enter) else $error("standby not entered");
	property p_lp_leave;
		status_o.state == FCS_LOW_POWER && wake_i && !low_power_request_i
			|=> status_o.state == FCS_ACTIVE && !bypass_mode_o;
	endproperty
	a_lp_leave: assert property (p_lp_leave) else $error("standby not left");
	property p_powerup;
		powerup_start_o |-> status_o.state == FCS_ACTIVE && $past(status_o.state) inside {FCS_OFF, FCS_SAFE}
			##1 !powerup_start_o;
	endproperty
	a_powerup: assert property (p_powerup) else $error("bad power-up pulse");
	c_latch: cover property (status_o.state == FCS_LATCH);
	c_lp: cover property (status_o.state == FCS_LOW_POWER);
	c_safe_out: cover property (status_o.state == FCS_SAFE ##1 status_o.state == FCS_ACTIVE);
endmodule
//////////////////////////////////////////////////////////////////
bind fcs_supervisor fcs_supervisor_props props_u (.clk_i, .rstn_i, .faults_i, .battery_supply_ok_i,
	.wake_i, .low_power_request_i, .regulators_en_o, .bypass_mode_o, .monitor_en_o, .powerup_start_o,
	.watchdog_fault_out_o, .status_o);

/* File: testbench/fcs_monitor_model.sv */
// Model of the analog monitors and the wake and standby pins.
`timescale 1ns/1ps
module fcs_monitor_model
	import fcs_pkg::*;
(
	// Clock that paces pin changes.
	input wire logic clk_i,
	// Levels seen by the supervisor.
	output fcs_faults_s faults_o,
	output logic supply_ok_o,
	output logic wake_o,
	output logic low_power_request_o
);
	// Good supply and wake from power-on, so the supervisor may start.
	initial begin
		faults_o = fcs_faults_s'(4'h0);
		supply_ok_o = 1'b1;
		wake_o = 1'b1;
		low_power_request_o = 1'b0;
	end
	// Levels move after a falling edge, away from the sampling edge.
	task automatic drive(input logic [3:0] f, input logic w, input logic lp);
		@(negedge clk_i);
		faults_o = fcs_faults_s'(f);
		wake_o = w;
		low_power_request_o = lp;
	endtask
	// The supply level also moves after a falling edge.
	task automatic set_supply(input logic ok);
		@(negedge clk_i);
		supply_ok_o = ok;
	endtask
endmodule

/* File: testbench/tb_fcs_supervisor.sv */
// Self-checking bench of the fault supervisor.
`timescale 1ns/1ps
module tb_fcs_supervisor
	import fcs_pkg::*;
;
	localparam int SHORT = 20;
	localparam logic [3:0] OT = 4'h8;
	localparam logic [3:0] PU = 4'h4;
	localparam logic [3:0] SU = 4'h2;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	fcs_faults_s faults;
	logic sup_ok, wake, lp_req, reg_en, bypass, mon_en, pwrup, watchdog_fault_out;
	fcs_status_s status_o;
	int error_cnt = 0;
	int num_checks = 0;
	// 25 MHz clock.
	always #20 clk_i = ~clk_i;
	fcs_monitor_model mon_u (.clk_i(clk_i), .faults_o(faults), .supply_ok_o(sup_ok), .wake_o(wake),
		.low_power_request_o(lp_req));
	// Short windows keep the run brief; long is three times short.
	fcs_supervisor #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(60)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
		.faults_i(faults), .battery_supply_ok_i(sup_ok), .wake_i(wake), .low_power_request_i(lp_req),
		.regulators_en_o(reg_en), .bypass_mode_o(bypass), .monitor_en_o(mon_en), .powerup_start_o(pwrup),
		.watchdog_fault_out_o(watchdog_fault_out), .status_o(status_o));
	//////////////////////////////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Compares state, count and window together.
	task automatic chk(input fcs_state_e s, input logic [2:0] c, input logic wl);
		num_checks++;
		if ({status_o.state, status_o.persistent_fault_count, status_o.window_long} !== {s, c, wl}) begin
			error_cnt++;
			$display("unexpected status at %0t: %0h vs %0h", $time,
				{status_o.state, status_o.persistent_fault_count, status_o.window_long}, {s, c, wl});
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected bit at %0t: %0h vs %0h", $time, got, exp);
		end
	endtask
	// A fault needs two edges to show: one to register, one to decide.
	task automatic fault(input logic [3:0] f);
		mon_u.drive(f, 1'b1, 1'b0);
		step(2);
	endtask
	task automatic t_supply_first;
		fault(SU);
		chk(FCS_SAFE, 3'h0, 1'b1);
		fault(4'h0);
		chk(FCS_ACTIVE, 3'h0, 1'b1);
		chk_bit(pwrup, 1'b1);
		chk_bit(reg_en, 1'b1);
		step(2);
		chk_bit(status_o.refresh_running, 1'b0);
		chk_bit(pwrup, 1'b0);
	endtask
	task automatic t_pump_refresh;
		fault(PU);
		chk(FCS_SAFE, 3'h1, 1'b0);
		fault(4'h0);
		step(1);
		chk_bit(status_o.refresh_running, 1'b1);
		step(SHORT - 8);
		chk(FCS_ACTIVE, 3'h1, 1'b0);
		step(12);
		chk(FCS_ACTIVE, 3'h0, 1'b1);
	endtask
	task automatic t_latch;
		fault(PU);
		fault(4'h0);
		fault(SU);
		chk(FCS_SAFE, 3'h1, 1'b0);
		fault(4'h0);
		fault(OT);
		chk(FCS_SAFE, 3'h2, 1'b1);
		fault(4'h0);
		fault(PU);
		chk(FCS_SAFE, 3'h3, 1'b1);
		fault(4'h0);
		fault(OT);
		chk(FCS_SAFE, 3'h4, 1'b1);
		step(1);
		chk(FCS_LATCH, 3'h4, 1'b1);
		chk_bit(watchdog_fault_out, 1'b0);
		chk_bit(mon_en, 1'b0);
		chk_bit(reg_en, 1'b0);
		fault(4'h0);
		step(2);
		chk(FCS_LATCH, 3'h4, 1'b1);
		mon_u.drive(4'h0, 1'b0, 1'b0);
		step(2);
		chk(FCS_OFF, 3'h0, 1'b1);
		mon_u.set_supply(1'b0);
		fault(4'h0);
		chk(FCS_OFF, 3'h0, 1'b1);
		mon_u.set_supply(1'b1);
		step(1);
		chk(FCS_ACTIVE, 3'h0, 1'b1);
		chk_bit(pwrup, 1'b1);
	endtask
	task automatic t_safe_faults;
		fault(SU);
		fault(SU | OT);
		chk(FCS_SAFE, 3'h1, 1'b1);
		fault(4'h0);
		fault(PU);
		fault(PU | OT);
		chk(FCS_SAFE, 3'h2, 1'b1);
		fault(PU | OT | SU);
		chk(FCS_SAFE, 3'h2, 1'b1);
		fault(4'h0);
		fault(SU);
		fault(SU | PU);
		chk(FCS_SAFE, 3'h3, 1'b0);
		fault(4'h0);
		step(SHORT + 4);
		chk(FCS_ACTIVE, 3'h0, 1'b1);
	endtask
	// Faults are ignored in low power; standby release returns to active.
	task automatic t_low_power;
		mon_u.drive(4'h0, 1'b1, 1'b1);
		step(2);
		chk(FCS_LOW_POWER, 3'h0, 1'b1);
		chk_bit(bypass, 1'b1);
		mon_u.drive(OT, 1'b1, 1'b1);
		step(3);
		chk(FCS_LOW_POWER, 3'h0, 1'b1);
		fault(4'h0);
		chk(FCS_ACTIVE, 3'h0, 1'b1);
	endtask
	// First over-temperature on a clean count, a window restart, then the other fault in a pump SAFE.
	task automatic t_overtemp_first;
		mon_u.drive(OT, 1'b1, 1'b0);
		step(1);
		chk(FCS_ACTIVE, 3'h0, 1'b1);
		step(1);
		chk(FCS_SAFE, 3'h1, 1'b1);
		mon_u.drive(4'h0, 1'b1, 1'b0);
		step(2);
		chk(FCS_ACTIVE, 3'h1, 1'b1);
		chk_bit(pwrup, 1'b1);
		chk_bit(status_o.refresh_running, 1'b1);
		step(10);
		fault(PU);
		chk(FCS_SAFE, 3'h2, 1'b1);
		fault(4'h0);
		step(50);
		chk(FCS_ACTIVE, 3'h2, 1'b1);
		step(20);
		chk(FCS_ACTIVE, 3'h0, 1'b1);
		fault(PU);
		chk(FCS_SAFE, 3'h1, 1'b0);
		fault(PU | OT);
		chk(FCS_SAFE, 3'h1, 1'b1);
		fault(4'h0);
		chk(FCS_ACTIVE, 3'h1, 1'b1);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Guards against a hang; the tests need well under 1000 cycles.
	initial begin
		repeat (5000) @(posedge clk_i);
		error_cnt++;
		conclude();
	end
	initial begin
		step(20);
		rstn_i = 1'b1;
		step(2);
		chk(FCS_ACTIVE, 3'h0, 1'b1);
		chk_bit(watchdog_fault_out, 1'b1);
		t_supply_first();
		t_pump_refresh();
		t_latch();
		t_safe_faults();
		t_low_power();
		t_overtemp_first();
		conclude();
	end
endmodule
